// >>> rtl/instruction_word_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Accept each instruction as one 14-bit word with opcode and operands.
// - Default one instruction cycle; literal and accumulator calls take two.
// - Plain return, literal return and interrupt return take two cycles.
// - Jumps, relative branches, bit skips and skip-on-zero counts take two cycles.
// - Indirect access with pointer into program memory adds one cycle.
// - One instruction cycle spans four oscillator clocks.
// - Any file register operand is read before modify and store.
// - Destination bit 0 routes result to accumulator, 1 to file register.
// - File address is seven bits, selecting register 0 through 127.
// - Byte format: file in bits 6-0, destination bit 7, opcode above.
// - Bit format: bit number 9-7, file 6-0, opcode 13-10.
// - Literal format: 8-bit immediate 7-0, opcode 13-8.
// - Absolute call and jump: 11-bit target 10-0, opcode 13-11.
// - Don't-care encoding bits never change the decoded outcome.
// - Pointer number field selects pointer zero or one.
// - Pointer mode selects pre/post increment/decrement around access.
module instruction_word_decoder
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic word_valid,
  input wire logic [13:0] instr_word,
  input wire logic pointer_num_in,
  input wire logic [1:0] pointer_mode_in,
  input wire logic ptr0_in_program,
  input wire logic ptr1_in_program,
  output logic word_ready,
  output insn_decode_pkg::format_t format_out,
  output logic [6:0] file_addr,
  output logic dest_is_file,
  output logic [2:0] bit_num,
  output logic [7:0] literal8,
  output logic [10:0] literal11,
  output logic pointer_num,
  output insn_decode_pkg::pointer_mode_t pointer_mode_field,
  output logic uses_file,
  output logic file_read_req,
  output logic file_write_req,
  output logic [1:0] cycle_count,
  output logic extra_cycle,
  output logic cycle_start,
  output logic [1:0] osc_phase,
  output logic insn_done
);
  import insn_decode_pkg::*;

  // ************************************************************
  // Decoding helpers
  // ************************************************************

  // Top bits classify the format; 11-bit targets use 3 opcode bits
  function automatic format_t classify(input logic [13:0] w);
    format_t f;
    f = FMT_BYTE;
    unique case (w[13:12])
      2'h0: f = FMT_BYTE;
      2'h1: f = FMT_BIT;
      2'h2: f = FMT_ABS;
      2'h3: f = FMT_LIT;
    endcase
    return f;
  endfunction : classify

  // Two-cycle instructions, decided from opcode bits only
  function automatic logic is_two_cycle(input logic [13:0] w);
    logic r;
    r = 1'b0;
    if (w[13:12] == 2'h2)
      r = 1'b1;
    else if (w[13:11] == 3'h3)
      r = 1'b1;
    else if (w[13:12] == 2'h0 && (w[11:8] == 4'hB || w[11:8] == 4'hF))
      r = 1'b1;
    else if (w[13:9] == 5'h19)
      r = 1'b1;
    else if (w[13:4] == 10'h000 && (w[3:0] == 4'h8 || w[3:0] == 4'h9 ||
             w[3:0] == 4'hA || w[3:0] == 4'hB || w[3:0] == 4'hE))
      r = 1'b1;
    else if (w[13:10] == 4'hD)
      r = 1'b1;
    return r;
  endfunction : is_two_cycle

  // Bit formats, and byte formats with bits 11-7 not all zero, name a file register
  function automatic logic names_file(input logic [13:0] w);
    return (w[13:12] == 2'h0 && w[11:7] != 5'h00) || w[13:12] == 2'h1;
  endfunction : names_file

  // Bit set and bit clear store the altered byte; the skips only test it
  function automatic logic is_bit_store(input logic [13:0] w);
    return w[13:11] == 3'h2;
  endfunction : is_bit_store

  // ************************************************************
  // Execution state and oscillator phase
  // ************************************************************
  exec_state_t state_reg;
  exec_state_t state_next;
  logic [1:0] phase_reg;
  logic [1:0] remain_reg;
  logic [13:0] word_reg;
  logic extra_reg;
  logic cycle_end;
  logic indirect_hit;
  logic indirect_sel_prog;

  assign cycle_end = (phase_reg == PHASE_LAST);
  assign word_ready = (state_reg == ST_IDLE) ||
                      (cycle_end && remain_reg == 2'h1 && state_reg != ST_EXEC) ||
                      (cycle_end && remain_reg == 2'h1 && !extra_reg);
  assign indirect_sel_prog = pointer_num_in ? ptr1_in_program : ptr0_in_program;
  assign indirect_hit = names_file(instr_word) && (instr_word[6:1] == 6'h00) &&
                        indirect_sel_prog;
  assign osc_phase = phase_reg;
  assign cycle_start = (state_reg != ST_IDLE) && (phase_reg == 2'h0);

  // Next state of the execution sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (word_valid)
          state_next = ST_EXEC;
      ST_EXEC:
        if (cycle_end && remain_reg == 2'h1)
        begin
          if (extra_reg)
            state_next = ST_EXTRA;
          else if (!word_valid)
            state_next = ST_IDLE;
        end
      ST_EXTRA:
        if (cycle_end)
          state_next = word_valid ? ST_EXEC : ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Four oscillator clocks per instruction cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_reg <= 2'h0;
    else if (state_reg == ST_IDLE && !word_valid)
      phase_reg <= 2'h0;
    else if (state_reg != ST_IDLE)
      phase_reg <= phase_reg + 2'h1;
  end

  // Instruction cycles left for the current word
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      remain_reg <= 2'h0;
    else if (word_valid && word_ready)
      remain_reg <= is_two_cycle(instr_word) ? CYCLES_TWO : CYCLES_ONE;
    else if (cycle_end && remain_reg > 2'h1)
      remain_reg <= remain_reg - 2'h1;
  end

  // Captured word and extra cycle flag
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_reg <= RESET_WORD;
      extra_reg <= 1'b0;
    end
    else if (word_valid && word_ready)
    begin
      word_reg <= instr_word;
      extra_reg <= indirect_hit;
    end
    else if (state_reg == ST_EXTRA && cycle_end)
      extra_reg <= 1'b0;
  end

  // ************************************************************
  // Field extraction
  // ************************************************************

  // Registered operand fields of the accepted word
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      format_out <= FMT_BYTE;
      file_addr <= 7'h00;
      dest_is_file <= 1'b0;
      bit_num <= 3'h0;
      literal8 <= 8'h00;
      literal11 <= 11'h000;
      pointer_num <= 1'b0;
      pointer_mode_field <= PTR_PRE_INC;
      uses_file <= 1'b0;
      cycle_count <= 2'h0;
    end
    else if (word_valid && word_ready)
    begin
      format_out <= classify(instr_word);
      file_addr <= instr_word[FILE_LSB +: FILE_W];
      dest_is_file <= instr_word[DEST_POS];
      bit_num <= instr_word[BITNUM_LSB +: BITNUM_W];
      literal8 <= instr_word[LIT_LSB +: LIT8_W];
      literal11 <= instr_word[LIT_LSB +: LIT11_W];
      pointer_num <= pointer_num_in;
      pointer_mode_field <= pointer_mode_t'(pointer_mode_in);
      uses_file <= names_file(instr_word);
      cycle_count <= is_two_cycle(instr_word) ? CYCLES_TWO : CYCLES_ONE;
    end
  end

  assign extra_cycle = extra_reg;

  // ************************************************************
  // Read-modify-write strobes
  // ************************************************************

  // Read in the second quarter, write back in the last
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_read_req <= 1'b0;
      file_write_req <= 1'b0;
    end
    else
    begin
      file_read_req <= uses_file && state_reg == ST_EXEC && phase_reg == 2'h0 &&
                       remain_reg == cycle_count;
      // Byte ops store per destination bit, bit ops unless they only test
      file_write_req <= uses_file && state_reg == ST_EXEC && phase_reg == 2'h2 &&
                        (format_out == FMT_BIT ? is_bit_store(word_reg) : dest_is_file) &&
                        remain_reg == cycle_count;
    end
  end

  // Instruction retires at the last quarter of its final cycle
  assign insn_done = cycle_end && ((state_reg == ST_EXTRA) ||
                     (state_reg == ST_EXEC && remain_reg == 2'h1 && !extra_reg));

  // ************************************************************
  // Checks
  // ************************************************************
  // Oscillator phase sequencing
  chk_phase_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg != ST_IDLE && phase_reg == 2'h3) |=> phase_reg == 2'h0)
    else $error("phase did not wrap after four clocks");
  chk_start_phase: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cycle_start |-> ##3 (cycle_end && state_reg != ST_IDLE))
    else $error("instruction cycle not four clocks long");
  chk_done_phase: assert property (@(posedge sys_clk) disable iff (!rst_n)
    insn_done |-> osc_phase == PHASE_LAST)
    else $error("instruction retired off the last quarter");
  chk_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg != ST_IDLE && !cycle_end) |-> !word_ready)
    else $error("word accepted in mid cycle");

  // Read-modify-write strobes
  chk_write_after_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    file_write_req |-> $past(file_read_req, 2))
    else $error("file write without earlier read");
  chk_read_uses_file: assert property (@(posedge sys_clk) disable iff (!rst_n)
    file_read_req |-> uses_file)
    else $error("read strobe for non-file instruction");
  chk_read_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    file_read_req |=> !file_read_req)
    else $error("read strobe longer than one clock");
  chk_write_dest_file: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (file_write_req && format_out == FMT_BYTE) |-> dest_is_file)
    else $error("write strobe with accumulator destination");
  chk_byte_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (file_read_req && format_out == FMT_BYTE && dest_is_file)
      |-> ##2 file_write_req)
    else $error("result for file destination not stored");
  chk_bit_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (file_read_req && format_out == FMT_BIT && is_bit_store(word_reg))
      |-> ##2 file_write_req)
    else $error("bit operation result not stored");

  // Operand fields
  chk_file_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready) |=> file_addr == $past(instr_word[6:0]))
    else $error("file address not taken from low bits");
  chk_dest_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready) |=> dest_is_file == $past(instr_word[7]))
    else $error("destination bit not taken");
  chk_bit_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready) |=> bit_num == $past(instr_word[9:7]))
    else $error("bit number field wrong");
  chk_lit_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready) |=> literal8 == $past(instr_word[7:0]) &&
      literal11 == $past(instr_word[10:0]))
    else $error("literal field wrong");
  chk_mode_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready) |=> pointer_mode_field == $past(pointer_mode_in))
    else $error("pointer mode not decoded");

  // Cycle counts
  chk_call_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready && instr_word[13:11] == 3'h4) |=> cycle_count == 2'h2)
    else $error("call not two cycles");
  chk_return_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready && instr_word == 14'h0008) |=> cycle_count == 2'h2)
    else $error("return not two cycles");
  chk_goto_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready && instr_word[13:11] == 3'h5) |=> cycle_count == 2'h2)
    else $error("jump not two cycles");
  chk_skip_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (word_valid && word_ready && instr_word[13:11] == 3'h3) |=> cycle_count == 2'h2)
    else $error("bit skip not two cycles");
  chk_extra_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_EXEC && cycle_end && remain_reg == 2'h1 && extra_reg)
      |=> state_reg == ST_EXTRA [*4])
    else $error("extra cycle not spent");

  // Main scenarios
  cov_two_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cycle_count == 2'h2 && insn_done);
  cov_extra: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_EXTRA);
  cov_rmw: cover property (@(posedge sys_clk) disable iff (!rst_n)
    file_read_req ##2 file_write_req);
  cov_back_to_back: cover property (@(posedge sys_clk) disable iff (!rst_n)
    insn_done && word_valid && word_ready);
  cov_bit_store: cover property (@(posedge sys_clk) disable iff (!rst_n)
    file_write_req && format_out == FMT_BIT);

endmodule : instruction_word_decoder
`default_nettype wire

// >>> common/insn_decode_pkg.sv
`default_nettype none
package insn_decode_pkg;

  // ************************************************************
  // Instruction word geometry
  // ************************************************************
  localparam int WORD_W = 14;
  localparam int FILE_W = 7;
  localparam int BITNUM_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int FILE_LSB = 0;
  localparam int DEST_POS = 7;
  localparam int BITNUM_LSB = 7;
  localparam int LIT_LSB = 0;
  localparam int OP_TOP = 13;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] CYCLES_ONE = 2'h1;
  localparam logic [1:0] CYCLES_TWO = 2'h2;
  localparam logic [13:0] RESET_WORD = 14'h0000;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0]
  {
    FMT_BYTE = 2'h0,
    FMT_BIT = 2'h1,
    FMT_LIT = 2'h3,
    FMT_ABS = 2'h2
  } format_t;

  typedef enum logic [1:0]
  {
    PTR_PRE_INC = 2'h0,
    PTR_PRE_DEC = 2'h1,
    PTR_POST_INC = 2'h2,
    PTR_POST_DEC = 2'h3
  } pointer_mode_t;

  // Execution phases; one bit changes per step except ST_EXTRA to ST_IDLE
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_EXTRA = 2'h3
  } exec_state_t;

endpackage : insn_decode_pkg
`default_nettype wire

// >>> testbench/fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Fetch side model: offers queued words and holds each until taken
// ************************************************************
module fetch_model
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic word_ready,
  output logic word_valid,
  output logic [13:0] instr_word,
  output logic pointer_num_in,
  output logic [1:0] pointer_mode_in,
  output logic ptr0_in_program,
  output logic ptr1_in_program
);
  logic [18:0] q[$];
  logic [18:0] cur;
  // Queue an entry: stall, program flag, mode, pointer number, word
  task automatic push(input logic [18:0] e);
    q.push_back(e);
  endtask : push
  // Drop pending entries
  task automatic flush();
    q.delete();
  endtask : flush
  // Offer words after the edge; an idle bus shows a changing pattern
  initial
  begin
    word_valid = 1'b0;
    instr_word = 14'h0000;
    {pointer_mode_in, pointer_num_in} = 3'h0;
    {ptr0_in_program, ptr1_in_program} = 2'h0;
    forever
    begin
      if (q.size() != 0 && rst_n && !q[0][18])
      begin
        cur = q.pop_front();
        // The pointer this word names carries the program flag, the other pointer its inverse
        {ptr0_in_program, ptr1_in_program} = cur[14] ? {~cur[17], cur[17]}
          : {cur[17], ~cur[17]};
        {pointer_mode_in, pointer_num_in, instr_word} = cur[16:0];
        word_valid = 1'b1;
        @(negedge sys_clk);
        while (!word_ready && rst_n)
          @(negedge sys_clk);
      end
      else
      begin
        if (q.size() != 0)
          q[0][18] = 1'b0;
        word_valid = 1'b0;
        instr_word = ~instr_word;
      end
      @(posedge sys_clk);
      #1;
    end
  end
endmodule : fetch_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import insn_decode_pkg::*;
  typedef struct packed {logic [13:0] w; logic pn; logic [1:0] pm; logic prog;} note_t;
  logic sys_clk, rst_n, word_valid, pointer_num_in, ptr0_in_program, ptr1_in_program;
  logic [13:0] instr_word;
  logic [1:0] pointer_mode_in, cycle_count, osc_phase;
  logic word_ready, dest_is_file, pointer_num, uses_file, file_read_req, file_write_req;
  logic extra_cycle, cycle_start, insn_done, two, uf, ex;
  format_t format_out;
  pointer_mode_t pointer_mode_field;
  logic [6:0] file_addr;
  logic [2:0] bit_num;
  logic [7:0] literal8;
  logic [10:0] literal11;
  logic [31:0] seed;
  note_t exp_q[$];
  note_t e;
  int err_count, cmp_count, cyc, take_cyc, rd_cnt, wr_cnt, st_cnt;
  localparam logic [13:0] DIR_W [19] = '{14'h0785, 14'h0780, 14'h2005, 14'h2FFF, 14'h1805,
    14'h1F85, 14'h0B85, 14'h0F80, 14'h3255, 14'h0008, 14'h0009, 14'h000A, 14'h000B,
    14'h000E, 14'h37AA, 14'h1405, 14'h30FF, 14'h0000, 14'h0705};
  // ************************************************************
  // Clock, partner and design
  // ************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  fetch_model src (.sys_clk(sys_clk), .rst_n(rst_n), .word_ready(word_ready),
    .word_valid(word_valid), .instr_word(instr_word), .pointer_num_in(pointer_num_in),
    .pointer_mode_in(pointer_mode_in), .ptr0_in_program(ptr0_in_program),
    .ptr1_in_program(ptr1_in_program));
  instruction_word_decoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .word_valid(word_valid),
    .instr_word(instr_word), .pointer_num_in(pointer_num_in),
    .pointer_mode_in(pointer_mode_in), .ptr0_in_program(ptr0_in_program),
    .ptr1_in_program(ptr1_in_program), .word_ready(word_ready), .format_out(format_out),
    .file_addr(file_addr), .dest_is_file(dest_is_file), .bit_num(bit_num),
    .literal8(literal8), .literal11(literal11), .pointer_num(pointer_num),
    .pointer_mode_field(pointer_mode_field), .uses_file(uses_file),
    .file_read_req(file_read_req), .file_write_req(file_write_req),
    .cycle_count(cycle_count), .extra_cycle(extra_cycle), .cycle_start(cycle_start),
    .osc_phase(osc_phase), .insn_done(insn_done));
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check_field(input logic [15:0] got, input logic [15:0] want);
    cmp_count++;
    if (got !== want)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check_field
  task automatic send(input logic [13:0] w, input logic [3:0] opt, input logic stall);
    exp_q.push_back({w, opt});
    src.push({stall, opt[0], opt[2:1], opt[3], w});
  endtask : send
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Cycle count and hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
    end
  end
  // ************************************************************
  // Result watcher: settled values are sampled mid-cycle
  // ************************************************************
  always @(negedge sys_clk)
  begin
    if (rst_n)
    begin
      rd_cnt += (file_read_req === 1'b1);
      wr_cnt += (file_write_req === 1'b1);
      st_cnt += (cycle_start === 1'b1);
      if (insn_done === 1'b1 && exp_q.size() == 0)
      begin
        err_count++;
        $display("unexpected at %0t: completion with nothing pending", $time);
      end
      else if (insn_done === 1'b1)
      begin
        e = exp_q.pop_front();
        two = (e.w[13:12] == 2'h2) || (e.w[13:11] == 3'h3) || (e.w[13:8] == 6'h0B)
          || (e.w[13:8] == 6'h0F) || (e.w[13:9] == 5'h19) || (e.w == 14'h000E)
          || (e.w[13:2] == 12'h002) || (e.w[13:10] == 4'hD);
        uf = (e.w[13:12] == 2'h0) ? (e.w[11:7] != 5'h00) : (e.w[13:12] == 2'h1);
        ex = uf && e.w[6:1] == 6'h00 && e.prog;
        check_field(16'(format_out), 16'(e.w[13:12]));
        check_field(16'(file_addr), 16'(e.w[6:0]));
        check_field(16'(dest_is_file), 16'(e.w[7]));
        check_field(16'(bit_num), 16'(e.w[9:7]));
        check_field(16'(literal8), 16'(e.w[7:0]));
        check_field(16'(literal11), 16'(e.w[10:0]));
        check_field(16'(pointer_num), 16'(e.pn));
        check_field(16'(pointer_mode_field), 16'(e.pm));
        check_field(16'(uses_file), 16'(uf));
        check_field(16'(rd_cnt), 16'(uf));
        if (e.w[13:12] == 2'h0 && uf)
          check_field(16'(wr_cnt), 16'(e.w[7]));
        else if (e.w[13:12] == 2'h1)
          check_field(16'(wr_cnt), 16'(e.w[13:11] == 3'h2));
        check_field(16'(cycle_count), two ? 16'h0002 : 16'h0001);
        check_field(16'(extra_cycle), 16'(ex));
        check_field(16'(osc_phase), 16'h0003);
        check_field(16'(st_cnt), 16'(two + 1 + ex));
        check_field(16'(cyc - take_cyc), 16'(4 * (two + 1 + ex)));
      end
      if (word_valid === 1'b1 && word_ready === 1'b1)
      begin
        take_cyc = cyc;
        rd_cnt = 0;
        wr_cnt = 0;
        st_cnt = 0;
      end
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {rst_n, err_count, cmp_count, cyc, take_cyc, rd_cnt, wr_cnt} = '0;
    seed = 32'h0000002F;
    repeat (3) @(posedge sys_clk);
    #1;
    check_field(16'({word_ready, insn_done, cycle_count}), 16'h0008);
    rst_n = 1'b1;
    // Every timing class, both pointers, all modes, with idle gaps
    for (int i = 0; i < 19; i++)
      send(DIR_W[i], 4'(i), i[2] & i[0]);
    // Random words, pointer fields and program flags
    repeat (300)
    begin
      seed = xs(seed);
      send(seed[13:0], seed[17:14], seed[18]);
    end
    wait (exp_q.size() == 0);
    // Reset in mid-instruction, then a fresh word
    send(14'h2005, 4'h0, 1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b0;
    exp_q.delete();
    src.flush();
    @(posedge sys_clk);
    #1;
    check_field(16'({word_ready, insn_done, cycle_count}), 16'h0008);
    rst_n = 1'b1;
    send(14'h3001, 4'h9, 1'b0);
    wait (exp_q.size() == 0);
    repeat (4) @(posedge sys_clk);
    summarize();
  end
endmodule : testbench
`default_nettype wire
